/* tb/signal_source.sv */
// Model of the measured signal and the reference clocks.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Free-running sources
// ----------------------------------------------------------------------
// Every source comes from one tick count, so gate and sample edges never meet a reference edge.
// Coinciding edges would make the expected counts depend on tie rules.
module signal_source (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Generated signals
    output logic      gateIn,
    output logic      extSource,
    output logic      intTimebase,
    output logic      sampleClk
);
    logic [15:0] tick;

    always @(negedge clk_sys) begin
        tick <= resetn ? tick + 16'h1 : 16'h0;
    end

    // Gate period 40 cycles, rising at 0 and falling at 20.
    assign gateIn      = (tick % 16'd40) < 16'd20;
    // Internal reference, period 4, rising at 1 and falling at 3.
    assign intTimebase = (tick % 16'd4 == 16'd1)
                         || (tick % 16'd4 == 16'd2);
    // External reference, period 8, rising at 1 and falling at 5.
    assign extSource   = (tick % 16'd8 >= 16'd1)
                         && (tick % 16'd8 <= 16'd4);
    // Sample clock period 80: the gate runs twice as fast.
    assign sampleClk   = (tick % 16'd80 >= 16'd2)
                         && (tick % 16'd80 <= 16'd41);
endmodule : signal_source

/* tb/test_period_frequency_counter.sv */
// Self-checking testbench of the period and frequency counter.
`timescale 1ns/100ps
module test_period_frequency_counter;
    import pfc_pkg::*;
    // ------------------------------------------------------------------
    // Signals, model and design
    // ------------------------------------------------------------------
    logic         clk_sys      = 1'b0;
    logic         resetn       = 1'b0;
    logic         arm          = 1'b0;
    logic         useExtSource = 1'b0;
    meas_cfg_t    cfg          = '0;
    logic         gateIn, extSource, intTimebase, sampleClk, busy;
    meas_result_t result;
    int           mismatches   = 0;
    int           checks_done  = 0;
    // A fixed gate of 81 cycles leaves exactly 80 counting cycles, two whole
    // gate periods, so the high frequency count is known for any phase.
    localparam int FIX_LEN     = 81;

    always #12.5 clk_sys = ~clk_sys;

    signal_source model (.clk_sys(clk_sys), .resetn(resetn),
        .gateIn(gateIn), .extSource(extSource),
        .intTimebase(intTimebase), .sampleClk(sampleClk));

    period_frequency_counter #(.GATE_LEN(FIX_LEN)) dut (.clk_sys(clk_sys),
        .resetn(resetn), .arm(arm), .cfg(cfg),
        .useExtSource(useExtSource), .gateIn(gateIn),
        .extSource(extSource), .intTimebase(intTimebase),
        .sampleClk(sampleClk), .result(result), .busy(busy));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic compare(input string what, input logic [31:0] exp,
                           input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, seen);
        end
    endtask : compare

    task automatic measure(input meas_mode_t m, input logic gr, input logic sr,
                           input logic ext, input logic avg,
                           input logic [7:0] div, input logic [31:0] expMain,
                           input logic [31:0] expAux, output int waited);
        @(negedge clk_sys);
        cfg.mode = m;
        cfg.gateRising = gr;
        cfg.srcRising = sr;
        cfg.averagingSelect = avg;
        cfg.divideDown = div;
        useExtSource = ext;
        arm = 1'b1;
        @(negedge clk_sys);
        arm = 1'b0;
        @(negedge clk_sys);
        compare("busy after arm", 32'h1, {31'h0, busy});
        waited = 2;
        while (result.valid !== 1'b1 && waited < 2000) begin
            @(negedge clk_sys);
            waited++;
        end
        compare("valid", 32'h1, {31'h0, result.valid});
        compare("mainCount", expMain, result.mainCount);
        compare("auxCount", expAux, result.auxCount);
        // Busy follows the state one cycle late, so it drops after valid.
        @(negedge clk_sys);
        compare("busy when done", 32'h0, {31'h0, busy});
        // Further gate edges pass by; the result must not move.
        repeat (90) @(negedge clk_sys);
        compare("held valid", 32'h1, {31'h0, result.valid});
        compare("held mainCount", expMain, result.mainCount);
        compare("held auxCount", expAux, result.auxCount);
    endtask : measure

    task automatic results;
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_idle;
        repeat (100) @(negedge clk_sys);
        compare("valid unarmed", 32'h0, {31'h0, result.valid});
    endtask : s_idle

    task automatic s_period;
        int w;
        measure(MODE_PERIOD, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 32'hA, 32'h0, w);
        measure(MODE_PERIOD, 1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 32'hA, 32'h0, w);
        measure(MODE_PERIOD, 1'b1, 1'b0, 1'b0, 1'b0, 8'h01, 32'hA, 32'h0, w);
        measure(MODE_PERIOD, 1'b1, 1'b1, 1'b1, 1'b0, 8'h01, 32'h5, 32'h0, w);
    endtask : s_period

    task automatic s_methods;
        int w;
        measure(MODE_ONE_CNT, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 32'hA, 32'h0, w);
        measure(MODE_LARGE_RNG, 1'b1, 1'b1, 1'b0, 1'b0, 8'h02, 32'h14, 32'h0, w);
        measure(MODE_HIGH_FREQ, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 32'h2, 32'h0, w);
        // Arm takes one cycle and the start one more before the fixed gate.
        compare("fixed gate time", 32'h1, {31'h0, w == FIX_LEN + 2});
    endtask : s_methods

    task automatic s_sampled;
        int w;
        measure(MODE_SAMPLED, 1'b1, 1'b1, 1'b0, 1'b1, 8'h01, 32'h14, 32'h2, w);
        measure(MODE_SAMPLED, 1'b1, 1'b1, 1'b0, 1'b0, 8'h01, 32'h14, 32'h0, w);
    endtask : s_sampled

    initial begin
        #500000;
        mismatches++;
        results();
    end

    initial begin
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        s_idle();
        s_period();
        s_methods();
        s_sampled();
        results();
    end
endmodule : test_period_frequency_counter

/* verilog/period_frequency_counter.sv */
// Period and frequency counter built from one pair of counters.
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Functional notes
// ----------------------------------------------------------------------
// Functional notes
// - Measurement starts only after arming, then measures one gate period in the period and one counter methods.
// - Gate active edge is selectable rising or falling.
// - Count one selected source edge per cycle between active gate edges.
// - Source may be internal timebase or external reference clock.
// - Result is the raw count of source edges; signal edges in the high frequency method and on the auxiliary counter.
// - Methods use one or two counters and return one measurement each.
// - High frequency method uses a fixed known gate length.
// - Sampled mode interval equals the sample clock period.
// - Counters pair in one fixed group, main counter with auxiliary counter.
// - Averaging: auxiliary counts signal, main counts timebase per sample.
module period_frequency_counter
    import pfc_pkg::*;
#(
    parameter int GATE_LEN = pfc_pkg::GATE_FIX_LEN
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    // Control
    input  wire logic                arm,
    input  wire pfc_pkg::meas_cfg_t  cfg,
    input  wire logic                useExtSource,
    // Measured and reference signals
    input  wire logic                gateIn,
    input  wire logic                extSource,
    input  wire logic                intTimebase,
    input  wire logic                sampleClk,
    // Result
    output pfc_pkg::meas_result_t    result,
    output logic                     busy
);
    import pfc_pkg::*;

    // ------------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------------
    logic gatePrev_reg, srcPrev_reg, sampPrev_reg;
    logic srcSel, gateEdge, srcEdge, sigEdge, sampEdge;
    logic fixedEnd;
    logic [31:0] fixCnt_reg;
    logic [7:0]  divCnt_reg;
    meas_state_t state_reg;
    meas_result_t result_reg;
    logic [31:0] mainCnt_reg, auxCnt_reg;

    function automatic logic edgeOf(input logic cur, input logic prev,
                                    input logic rising);
        edgeOf = rising ? (cur & ~prev) : (~cur & prev);
    endfunction : edgeOf

    assign srcSel   = useExtSource ? extSource : intTimebase;
    assign gateEdge = edgeOf(gateIn, gatePrev_reg, cfg.gateRising);
    assign srcEdge  = edgeOf(srcSel, srcPrev_reg, cfg.srcRising);
    assign sigEdge  = edgeOf(gateIn, gatePrev_reg, 1'b1);
    assign sampEdge = edgeOf(sampleClk, sampPrev_reg, 1'b1);
    assign fixedEnd = (fixCnt_reg == 32'(GATE_LEN - 1));

    // The previous samples follow the pins during reset as well, so a pin
    // that idles high cannot fake an edge on the first cycle after reset.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            gatePrev_reg <= gateIn;
            srcPrev_reg  <= srcSel;
            sampPrev_reg <= sampleClk;
        end else begin
            gatePrev_reg <= gateIn;
            srcPrev_reg  <= srcSel;
            sampPrev_reg <= sampleClk;
        end
    end

    // ------------------------------------------------------------------
    // Measurement sequencing
    // ------------------------------------------------------------------
    // The stop condition depends on the method; the pair of counters is
    // fixed so a second counter is always the partner of the first.
    logic startEv, stopEv;
    always_comb begin
        case (cfg.mode)
            MODE_HIGH_FREQ: begin
                startEv = 1'b1;
                stopEv  = fixedEnd;
            end
            MODE_SAMPLED: begin
                startEv = sampEdge;
                stopEv  = sampEdge;
            end
            MODE_LARGE_RNG: begin
                startEv = gateEdge;
                stopEv  = gateEdge
                          && (divCnt_reg == cfg.divideDown);
            end
            default: begin
                startEv = gateEdge;
                stopEv  = gateEdge;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE:  if (arm) state_reg <= ST_ARMED;
                ST_ARMED: if (startEv) state_reg <= ST_COUNT;
                ST_COUNT: if (stopEv) state_reg <= ST_DONE;
                ST_DONE:  if (arm) state_reg <= ST_ARMED;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // Fixed gate length and divide-down counters.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            fixCnt_reg <= CNT_RESET;
            divCnt_reg <= 8'h00;
        end else if (state_reg != ST_COUNT) begin
            fixCnt_reg <= CNT_RESET;
            divCnt_reg <= 8'h01;
        end else begin
            fixCnt_reg <= fixCnt_reg + 32'h0000_0001;
            if (gateEdge)
                divCnt_reg <= divCnt_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Counter pair
    // ------------------------------------------------------------------
    // In the high frequency method the fixed gate counter supplies the gate, so the
    // main counter counts signal edges instead of reference edges.
    logic mainInc, auxInc;
    assign mainInc = (cfg.mode == MODE_HIGH_FREQ) ? sigEdge : srcEdge;
    assign auxInc  = (cfg.mode == MODE_SAMPLED) && cfg.averagingSelect
                     && sigEdge;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            mainCnt_reg <= CNT_RESET;
            auxCnt_reg  <= CNT_RESET;
        end else if (state_reg == ST_ARMED && startEv) begin
            mainCnt_reg <= CNT_RESET;
            auxCnt_reg  <= CNT_RESET;
        end else if (state_reg == ST_COUNT && !stopEv) begin
            if (mainInc)
                mainCnt_reg <= mainCnt_reg + 32'h0000_0001;
            if (auxInc)
                auxCnt_reg <= auxCnt_reg + 32'h0000_0001;
        end
    end

    // Result is the raw count, held until the next arm.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            result_reg <= '0;
        end else if (state_reg == ST_COUNT && stopEv) begin
            result_reg.mainCount <= mainCnt_reg;
            result_reg.auxCount  <= auxCnt_reg;
            result_reg.valid     <= 1'b1;
        end else if (arm) begin
            result_reg.valid <= 1'b0;
        end
    end

    logic busy_reg;
    always_ff @(posedge clk_sys) begin
        if (!resetn)
            busy_reg <= 1'b0;
        else
            busy_reg <= (state_reg == ST_ARMED) || (state_reg == ST_COUNT);
    end

    assign result = result_reg;
    assign busy   = busy_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_doneHold;
        (state_reg == ST_DONE) && !arm;
    endsequence

    a_no_start_unarmed: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ST_IDLE && !arm) |=> state_reg != ST_COUNT)
        else $error("Counting began without arming.");
    a_result_held: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_doneHold |=> $stable(result_reg.mainCount))
        else $error("Result changed while held.");
    a_done_stays: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_doneHold |=> state_reg == ST_DONE)
        else $error("Left done state without arming.");
    a_count_step: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ST_COUNT && !stopEv && mainInc)
        |=> mainCnt_reg == $past(mainCnt_reg) + 32'h0000_0001)
        else $error("Counter missed a source edge.");
    a_result_raw: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ST_COUNT && stopEv)
        |=> result_reg.mainCount == $past(mainCnt_reg))
        else $error("Result is not the raw count.");
    a_fixed_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ST_COUNT && cfg.mode == MODE_HIGH_FREQ
         && fixedEnd) |=> state_reg == ST_DONE)
        else $error("Fixed gate did not end on time.");
    a_sample_stop: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ST_COUNT && cfg.mode == MODE_SAMPLED && sampEdge)
        |=> state_reg == ST_DONE)
        else $error("Sample edge did not end the interval.");
    a_aux_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ST_COUNT && !cfg.averagingSelect && !stopEv)
        |=> $stable(auxCnt_reg))
        else $error("Auxiliary counter ran without averaging.");
    a_gate_edge: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == ST_ARMED && cfg.mode == MODE_PERIOD && !gateEdge)
        |=> state_reg == ST_ARMED)
        else $error("Started without an active gate edge.");

endmodule : period_frequency_counter

/* verilog/pfc_pkg.sv */
// Package holding constants and carrier types of the period counter.
package pfc_pkg;

    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int        CNT_W        = 32;
    localparam logic [31:0] CNT_RESET  = 32'h0000_0000;
    localparam int        GATE_FIX_LEN = 40000;  // Fixed gate, 1 ms at 40 MHz.
    localparam int        NUM_CNT      = 4;

    // ------------------------------------------------------------------
    // Measurement methods
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_PERIOD    = 3'h0,
        MODE_ONE_CNT   = 3'h1,
        MODE_HIGH_FREQ = 3'h2,
        MODE_LARGE_RNG = 3'h3,
        MODE_SAMPLED   = 3'h4
    } meas_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_COUNT = 2'b11,
        ST_DONE  = 2'b10
    } meas_state_t;

    // Configuration travelling as one group.
    typedef struct packed {
        meas_mode_t mode;
        logic       gateRising;
        logic       srcRising;
        logic       averagingSelect;
        logic [7:0] divideDown;
    } meas_cfg_t;

    // Result travelling as one group.
    typedef struct packed {
        logic [31:0] mainCount;
        logic [31:0] auxCount;
        logic        valid;
    } meas_result_t;

endpackage : pfc_pkg
